// *** core/exec_core.sv ***
// execution core: skip, increment, jump and or instructions
//
// Function
// - decrement file, result to accumulator or file
// - zero skip result squashes next, two cycles
// - nonzero skip result continues in sequence
// - increment file, routed; only plain updates zero
// - jump loads 11-bit immediate into pc low
// - jump fills pc 12:11 from latch 4:3
// - jump takes two cycles, flags unchanged
// - or literal into accumulator, updates zero
// - or accumulator with file, routed, updates zero
`timescale 1ns/1ps
`default_nettype none
module exec_core
	import exec_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// instruction
	input  wire logic        valid_in,
	input  wire logic [2:0]  op_in,
	input  wire logic        target_sel_in,
	input  wire logic [10:0] immediate_value_in,
	input  wire logic [4:0]  upper_pc_latch_in,
	// file register read data
	input  wire logic [7:0]  file_rdata_in,
	// file register write
	output var  logic        file_we_out,
	output var  logic [7:0]  file_wdata_out,
	// core state
	output var  logic [7:0]  acc_out,
	output var  logic        zero_out,
	output var  logic [12:0] pc_out,
	output var  logic        squash_out,
	output var  logic        busy_out
);
	logic [7:0]  alu_res;
	logic        alu_zero;
	state_t      state_q, state_d;
	logic [7:0]  acc_q, acc_d;
	logic        zero_q, zero_d;
	logic [12:0] pc_q, pc_d;
	logic        we_q, we_d;
	logic [7:0]  wdata_q, wdata_d;
	logic        squash_q, squash_d;
	logic        busy_q, busy_d;
	logic        take;
	op_t         op;

	exec_alu u_alu (
		.op_in   (op_in),
		.acc_in  (acc_q),
		.file_in (file_rdata_in),
		.lit_in  (immediate_value_in[7:0]),
		.res_out (alu_res),
		.zero_out(alu_zero)
	);

	assign op = op_t'(op_in);
	assign take = valid_in && (state_q == ST_RUN);

	// true for the two skip-on-zero opcodes
	function automatic logic is_skip(input op_t code);
		return (code == OP_DEC_SKIP) || (code == OP_INC_SKIP);
	endfunction

	always_comb begin
		state_d = ST_RUN;
		acc_d = acc_q;
		zero_d = zero_q;
		pc_d = pc_q;
		we_d = 1'b0;
		wdata_d = alu_res;
		squash_d = 1'b0;
		if (take) begin
			pc_d = pc_q + ONE_13;
			case (op)
				OP_DEC_SKIP, OP_INC_SKIP: begin
					if (target_sel_in) we_d = 1'b1;
					else acc_d = alu_res;
					if (alu_zero) begin
						state_d = ST_FLUSH;
						squash_d = 1'b1;
					end
				end
				OP_INC, OP_OR_REG: begin
					if (target_sel_in) we_d = 1'b1;
					else acc_d = alu_res;
					zero_d = alu_zero;
				end
				OP_OR_LIT: begin
					acc_d = alu_res;
					zero_d = alu_zero;
				end
				OP_JUMP: begin
					pc_d = {upper_pc_latch_in[LATCH_HI:LATCH_LO],
						immediate_value_in};
					state_d = ST_FLUSH;
					squash_d = 1'b1;
				end
				default: pc_d = pc_q + ONE_13;
			endcase
		end else if (state_q == ST_FLUSH) begin
			state_d = ST_RUN;
		end
		busy_d = (state_d == ST_FLUSH);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= ST_RUN;
			acc_q <= ACC_RST;
			zero_q <= 1'b0;
			pc_q <= PC_RST;
			we_q <= 1'b0;
			wdata_q <= ACC_RST;
			squash_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			acc_q <= acc_d;
			zero_q <= zero_d;
			pc_q <= pc_d;
			we_q <= we_d;
			wdata_q <= wdata_d;
			squash_q <= squash_d;
			busy_q <= busy_d;
		end
	end

	assign acc_out = acc_q;
	assign zero_out = zero_q;
	assign pc_out = pc_q;
	assign file_we_out = we_q;
	assign file_wdata_out = wdata_q;
	assign squash_out = squash_q;
	assign busy_out = busy_q;

	a_reset_clear: assert property (
		@(posedge clk_in) !rst_n_in
		|=> acc_out == ACC_RST && pc_out == PC_RST && !zero_out &&
		!file_we_out && file_wdata_out == ACC_RST && !squash_out &&
		!busy_out)
		else $error("reset did not clear the core state");
	a_skip_zero: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && is_skip(op) && alu_zero
		|=> squash_out && busy_out ##1 !busy_out)
		else $error("skip on zero did not insert one squash cycle");
	a_no_skip: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && is_skip(op) && !alu_zero
		|=> !busy_out && !squash_out)
		else $error("nonzero skip result still skipped");
	a_pc_step: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && op != OP_JUMP |=> pc_out == $past(pc_out) + ONE_13)
		else $error("program counter did not step by one");
	a_nop_cycle: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		busy_out |=> $stable(pc_out) && $stable(acc_out) &&
		$stable(zero_out) && !file_we_out && !busy_out)
		else $error("instruction taken during squash cycle");
	a_dec_file: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && op == OP_DEC_SKIP && target_sel_in
		|=> file_we_out && file_wdata_out == $past(file_rdata_in) - 8'h01)
		else $error("decrement write back wrong");
	a_dec_acc: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && op == OP_DEC_SKIP && !target_sel_in
		|=> acc_out == $past(file_rdata_in) - 8'h01 && !file_we_out)
		else $error("decrement to accumulator wrong");
	a_inc_acc: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && (op == OP_INC || op == OP_INC_SKIP) && !target_sel_in
		|=> acc_out == $past(file_rdata_in) + 8'h01 && !file_we_out)
		else $error("increment to accumulator wrong");
	a_inc_file: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && (op == OP_INC || op == OP_INC_SKIP) && target_sel_in
		|=> file_we_out && file_wdata_out == $past(file_rdata_in) + 8'h01)
		else $error("increment write back wrong");
	a_inc_zero: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && op == OP_INC
		|=> zero_out == ($past(file_rdata_in) + 8'h01 == 8'h00))
		else $error("increment zero flag wrong");
	a_skip_flags: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && (is_skip(op) || op == OP_JUMP) |=> $stable(zero_out))
		else $error("skip or jump changed zero flag");
	a_jump_pc: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && op == OP_JUMP |=> pc_out == {$past(upper_pc_latch_in[4:3]),
		$past(immediate_value_in)} && busy_out)
		else $error("jump target wrong");
	a_jump_two: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && op == OP_JUMP |=> busy_out ##1 !busy_out)
		else $error("jump not two cycles");
	a_or_lit: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && op == OP_OR_LIT |=> acc_out == ($past(acc_q) |
		$past(immediate_value_in[7:0])) && zero_out == (acc_out == 8'h00))
		else $error("or literal wrong");
	a_or_reg: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && op == OP_OR_REG && target_sel_in |=> file_we_out &&
		file_wdata_out == ($past(acc_q) | $past(file_rdata_in)) &&
		zero_out == (file_wdata_out == 8'h00))
		else $error("or register wrong");
	a_or_acc: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && op == OP_OR_REG && !target_sel_in |=> !file_we_out &&
		acc_out == ($past(acc_q) | $past(file_rdata_in)) &&
		zero_out == (acc_out == 8'h00))
		else $error("or to accumulator wrong");
	a_wrap_inc: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		take && op == OP_INC && file_rdata_in == 8'hFF && target_sel_in
		|=> file_wdata_out == 8'h00 && zero_out)
		else $error("increment did not wrap");
	c_skip: cover property (@(posedge clk_in) take && op == OP_DEC_SKIP &&
		alu_zero);
	c_jump: cover property (@(posedge clk_in) take && op == OP_JUMP);
	c_or_zero: cover property (@(posedge clk_in) take && op == OP_OR_REG &&
		alu_zero);
	c_inc_wrap: cover property (@(posedge clk_in) take && op == OP_INC &&
		file_rdata_in == 8'hFF);
	c_nop_cycle: cover property (@(posedge clk_in) busy_out && valid_in);
endmodule : exec_core
`default_nettype wire

// *** core/exec_pkg.sv ***
// package: opcodes, widths and reset values for the execution slice
package exec_pkg;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W = 13;
	localparam int JUMP_W = 11;
	localparam int LATCH_HI = 4;
	localparam int LATCH_LO = 3;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [12:0] PC_RST = 13'h0000;
	localparam logic [7:0] ONE_8 = 8'h01;
	localparam logic [12:0] ONE_13 = 13'h0001;
	localparam int JUMP_CYCLES = 2;
	localparam int SKIP_CYCLES = 2;

	typedef enum logic [2:0] {
		OP_NONE      = 3'h0,
		OP_DEC_SKIP  = 3'h1,
		OP_INC_SKIP  = 3'h2,
		OP_INC       = 3'h3,
		OP_JUMP      = 3'h4,
		OP_OR_LIT    = 3'h5,
		OP_OR_REG    = 3'h6
	} op_t;

	typedef enum logic [1:0] {
		ST_RUN    = 2'h0,
		ST_FLUSH  = 2'h1
	} state_t;
endpackage : exec_pkg

// *** core/exec_alu.sv ***
// alu: increment, decrement and or with zero detect
`timescale 1ns/1ps
`default_nettype none
module exec_alu
	import exec_pkg::*;
(
	// operands
	input  wire logic [2:0] op_in,
	input  wire logic [7:0] acc_in,
	input  wire logic [7:0] file_in,
	input  wire logic [7:0] lit_in,
	// result
	output var  logic [7:0] res_out,
	output var  logic       zero_out
);
	always_comb begin
		case (op_t'(op_in))
			OP_DEC_SKIP: res_out = file_in - ONE_8;
			OP_INC_SKIP: res_out = file_in + ONE_8;
			OP_INC:      res_out = file_in + ONE_8;
			OP_OR_LIT:   res_out = acc_in | lit_in;
			OP_OR_REG:   res_out = acc_in | file_in;
			default:     res_out = file_in;
		endcase
		zero_out = (res_out == 8'h00);
	end
endmodule : exec_alu
`default_nettype wire

// *** bench/exec_core_tb.sv ***
// self-checking bench for the execution core
`timescale 1ns/1ps
`default_nettype none
module exec_core_tb
	import exec_pkg::*;
;
	logic        clk_in, rst_n_in, valid_in, target_sel_in;
	logic [2:0]  op_in;
	logic [10:0] immediate_value_in;
	logic [4:0]  upper_pc_latch_in;
	logic [7:0]  file_rdata_in, file_wdata_out, acc_out;
	logic        file_we_out, zero_out, squash_out, busy_out;
	logic [12:0] pc_out, m_pc;
	logic [7:0]  m_acc, m_wd, r;
	logic        m_z, m_we, m_sq, m_busy;
	logic [7:0]  edge_v [4] = '{8'h00, 8'h01, 8'hFF, 8'h80};
	integer      seed = 32'h6B9F;
	int          n_errors = 0;
	int          checked = 0;

	exec_core exec_core_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.valid_in(valid_in), .op_in(op_in), .target_sel_in(target_sel_in),
		.immediate_value_in(immediate_value_in),
		.upper_pc_latch_in(upper_pc_latch_in),
		.file_rdata_in(file_rdata_in), .file_we_out(file_we_out),
		.file_wdata_out(file_wdata_out), .acc_out(acc_out),
		.zero_out(zero_out), .pc_out(pc_out), .squash_out(squash_out),
		.busy_out(busy_out));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic chk_v(input logic [12:0] got, input logic [12:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_f(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// route a result by the target select
	task automatic put(input logic [7:0] v);
		if (target_sel_in) begin
			m_we = 1'b1;
			m_wd = v;
		end else
			m_acc = v;
	endtask

	// reference model, fed the inputs sampled at this edge
	task automatic model;
		m_we = 1'b0;
		m_sq = 1'b0;
		if (valid_in && !m_busy) begin
			m_pc = m_pc + ONE_13;
			case (op_in)
			OP_DEC_SKIP, OP_INC_SKIP: begin
				r = (op_in == OP_DEC_SKIP) ? file_rdata_in - ONE_8
					: file_rdata_in + ONE_8;
				put(r);
				m_sq = (r == 8'h00);
			end
			OP_INC: begin
				r = file_rdata_in + ONE_8;
				put(r);
				m_z = (r == 8'h00);
			end
			OP_JUMP: begin
				m_pc = {upper_pc_latch_in[LATCH_HI:LATCH_LO],
					immediate_value_in};
				m_sq = 1'b1;
			end
			OP_OR_LIT: begin
				m_acc = m_acc | immediate_value_in[7:0];
				m_z = (m_acc == 8'h00);
			end
			OP_OR_REG: begin
				r = m_acc | file_rdata_in;
				put(r);
				m_z = (r == 8'h00);
			end
			default: ;
			endcase
		end
		m_busy = m_sq;
	endtask

	initial begin
		{rst_n_in, valid_in, op_in, target_sel_in} = '0;
		{immediate_value_in, upper_pc_latch_in, file_rdata_in} = '0;
		{m_acc, m_pc, m_wd, m_z, m_we, m_sq, m_busy} = '0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3000) begin
			@(posedge clk_in);
			model();
			valid_in <= ($random(seed) % 4) != 0;
			op_in <= 3'($random(seed));
			target_sel_in <= 1'($random(seed));
			immediate_value_in <= 11'($random(seed));
			upper_pc_latch_in <= 5'($random(seed));
			if ($random(seed) % 2 == 0)
				file_rdata_in <= edge_v[2'($random(seed))];
			else
				file_rdata_in <= 8'($random(seed));
			@(negedge clk_in);
			chk_v(13'(acc_out), 13'(m_acc));
			chk_f(zero_out, m_z);
			chk_v(pc_out, m_pc);
			chk_f(squash_out, m_sq);
			chk_f(busy_out, m_busy);
			chk_f(file_we_out, m_we);
			if (m_we)
				chk_v(13'(file_wdata_out), 13'(m_wd));
		end
		report_and_stop();
	end

	initial begin
		#60000;
		n_errors++;
		report_and_stop();
	end
endmodule // exec_core_tb
`default_nettype wire
